// [inc/dcr_pkg.sv]
// Purpose: shared constants and types of the dac code / power-down control block
// Assumes: 32-bit axi4-lite register bus, 16-bit serial frame
// Notes: byte offsets are word aligned

package dcr_pkg;

	localparam int CODE_W = 12;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// frame and register field positions
	localparam int CODE_LSB = 0;
	localparam int CODE_MSB = 11;
	localparam int MODE_LSB = 12;
	localparam int MODE_MSB = 13;
	localparam int STAT_AMP_BIT = 14;
	localparam int STAT_FRAME_BIT = 15;
	localparam int CTRL_HOLD_BIT = 0;

	// code range of the resistor string
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
	localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
	localparam logic [CODE_W:0] CODE_COUNT = 13'h1000;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SOFT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FRAMES = 8'h0c;

	localparam logic CTRL_HOLD_RST = 1'b0;
	localparam logic [15:0] FRAMES_RST = 16'h0000;
	localparam logic [15:0] FRAMES_ONE = 16'h0001;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		DCR_PM_NORMAL = 2'h0,
		DCR_PM_1K = 2'h1,
		DCR_PM_100K = 2'h2,
		DCR_PM_HIZ = 2'h3
	} dcr_pmode_t;

endpackage

// [inc/dcr_link_if.sv]
// Purpose: carries the captured frame word from the link end to the core
// Assumes: word only changes at a frame end, tgl flips once per frame end
// Notes: core must cross tgl through two flops before using word

`timescale 1ns/10ps

interface dcr_link_if;
	logic [dcr_pkg::WORD_W-1:0] word;
	logic tgl;

	modport link
	(
		output word,
		output tgl
	);

	modport core
	(
		input word,
		input tgl
	);
endinterface

// [src/dcr_link.sv]
// Purpose: serial shift register and frame-end capture on the link clocks
// Assumes: shift clock and frame select come from the host
// Notes: capture is clocked by the frame select rising edge itself

`timescale 1ns/10ps

module dcr_link
(
	input wire logic shift_clk,
	input wire logic clr_n,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	output logic serial_chain_out,
	output logic serial_chain_oe,
	dcr_link_if.link lk
);

	typedef struct packed
	{
		logic [dcr_pkg::WORD_W-1:0] sh;
	} dcr_shift_st_t;

	typedef struct packed
	{
		logic [dcr_pkg::WORD_W-1:0] word;
		logic tgl;
	} dcr_cap_st_t;

	dcr_shift_st_t s_q;
	dcr_shift_st_t s_d;
	dcr_cap_st_t c_q;
	dcr_cap_st_t c_d;

	////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_d = s_q;
		if (!frame_sel_n)
		begin
			s_d.sh = {s_q.sh[dcr_pkg::WORD_W-2:0], serial_in};
		end
	end

	// shift on falling edges; input ignored while select is high
	always_ff @(negedge shift_clk or negedge clr_n)
	begin
		if (!clr_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		c_d.word = s_q.sh;
		c_d.tgl = ~c_q.tgl;
	end

	// shift clock may be stopped at frame end, so the select edge clocks the capture
	always_ff @(posedge frame_sel_n or negedge clr_n)
	begin
		if (!clr_n)
			c_q <= '0;
		else
			c_q <= c_d;
	end

	assign lk.word = c_q.word;
	assign lk.tgl = c_q.tgl;
	assign serial_chain_out = s_q.sh[dcr_pkg::WORD_W-1];
	assign serial_chain_oe = ~frame_sel_n;

endmodule

// [src/dcr_top.sv]
// Purpose: dac code and power-down control with serial link and axi4-lite registers
// Assumes: clk 10 MHz, link shift clock unrelated, clear pin asynchronous
// Notes: bus state survives the clear pin, dac state does not

`timescale 1ns/10ps

module dcr_top
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dcr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dcr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dcr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [dcr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shift_clk,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	output logic serial_chain_out,
	output logic serial_chain_oe,
	input wire logic async_zero_n,
	output logic [dcr_pkg::CODE_W-1:0] dac_tap,
	output logic power_mode_hi,
	output logic power_mode_lo,
	output logic amp_enable,
	output logic gnd_1k_en,
	output logic gnd_100k_en
);

	typedef struct packed
	{
		logic aw_held;
		logic [dcr_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [dcr_pkg::DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [dcr_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic hold;
	} dcr_bus_st_t;

	typedef struct packed
	{
		logic [1:0] tgl_sync;
		logic tgl_seen;
		logic [1:0] fsel_sync;
		logic [dcr_pkg::CODE_W-1:0] code;
		dcr_pkg::dcr_pmode_t mode;
		logic amp_on;
		logic gnd_1k;
		logic gnd_100k;
		logic [15:0] frames;
	} dcr_dac_st_t;

	typedef struct packed
	{
		logic [1:0] rel;
	} dcr_rel_st_t;

	dcr_bus_st_t b_q;
	dcr_bus_st_t b_d;
	dcr_dac_st_t d_q;
	dcr_dac_st_t d_d;
	dcr_rel_st_t r_q;
	dcr_rel_st_t r_d;

	logic clr_n;
	logic soft_go;
	logic [dcr_pkg::WORD_W-1:0] soft_word;
	logic [dcr_pkg::WORD_W-1:0] cur_word;
	logic frame_evt;
	logic [dcr_pkg::WORD_W-1:0] new_word;
	logic apply;
	logic dac_rst_n;

	dcr_link_if lk ();

	////////////////////////////////////////////////////////////////////////////
	// clear pin and power-on reset share one asynchronous path into dac state

	assign clr_n = rst_n & async_zero_n;

	// clear drops dac state at once, but its release is a pin edge that may land
	// right on a clk edge, so the release is retimed through two flops
	always_comb
	begin
		r_d.rel = {r_q.rel[0], 1'b1};
	end

	always_ff @(posedge clk or negedge clr_n)
	begin
		if (!clr_n)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign dac_rst_n = r_q.rel[1];

	dcr_link u_link
	(
		.shift_clk(shift_clk),
		.clr_n(clr_n),
		.frame_sel_n(frame_sel_n),
		.serial_in(serial_in),
		.serial_chain_out(serial_chain_out),
		.serial_chain_oe(serial_chain_oe),
		.lk(lk.link)
	);

	////////////////////////////////////////////////////////////////////////////
	// register bus

	function automatic logic [dcr_pkg::ADDR_W-1:0] word_addr(input logic [dcr_pkg::ADDR_W-1:0] a);
		word_addr = {a[dcr_pkg::ADDR_W-1:2], 2'h0};
	endfunction

	assign cur_word = {2'h0, d_q.mode, d_q.code};

	always_comb
	begin
		b_d = b_q;
		soft_go = 1'b0;
		soft_word = cur_word;
		if (b_q.bvalid && s_axi_bready)
		begin
			b_d.bvalid = 1'b0;
		end
		if (b_q.rvalid && s_axi_rready)
		begin
			b_d.rvalid = 1'b0;
		end
		if (s_axi_awvalid && !b_q.aw_held)
		begin
			b_d.aw_held = 1'b1;
			b_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !b_q.w_held)
		begin
			b_d.w_held = 1'b1;
			b_d.w_data = s_axi_wdata;
			b_d.w_strb = s_axi_wstrb;
		end
		// write completes once both halves are held and the last response is gone
		if (b_q.aw_held && b_q.w_held && !b_q.bvalid)
		begin
			b_d.aw_held = 1'b0;
			b_d.w_held = 1'b0;
			b_d.bvalid = 1'b1;
			b_d.bresp = dcr_pkg::RESP_OKAY;
			case (word_addr(b_q.aw_addr))
				dcr_pkg::OFS_CTRL:
				begin
					if (b_q.w_strb[0])
						b_d.hold = b_q.w_data[dcr_pkg::CTRL_HOLD_BIT];
				end
				dcr_pkg::OFS_SOFT:
				begin
					soft_go = |b_q.w_strb[1:0];
					if (b_q.w_strb[0])
						soft_word[7:0] = b_q.w_data[7:0];
					if (b_q.w_strb[1])
						soft_word[15:8] = b_q.w_data[15:8];
				end
				dcr_pkg::OFS_STATUS, dcr_pkg::OFS_FRAMES:
				begin
					// read-only: write accepted and dropped
				end
				default:
				begin
					b_d.bresp = dcr_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_arvalid && !b_q.rvalid)
		begin
			b_d.rvalid = 1'b1;
			b_d.rresp = dcr_pkg::RESP_OKAY;
			b_d.rdata = '0;
			case (word_addr(s_axi_araddr))
				dcr_pkg::OFS_STATUS:
				begin
					b_d.rdata[dcr_pkg::CODE_MSB:dcr_pkg::CODE_LSB] = d_q.code;
					b_d.rdata[dcr_pkg::MODE_MSB:dcr_pkg::MODE_LSB] = d_q.mode;
					b_d.rdata[dcr_pkg::STAT_AMP_BIT] = d_q.amp_on;
					b_d.rdata[dcr_pkg::STAT_FRAME_BIT] = ~d_q.fsel_sync[1];
				end
				dcr_pkg::OFS_CTRL:
				begin
					b_d.rdata[dcr_pkg::CTRL_HOLD_BIT] = b_q.hold;
				end
				dcr_pkg::OFS_SOFT:
				begin
					b_d.rdata[dcr_pkg::WORD_W-1:0] = cur_word;
				end
				dcr_pkg::OFS_FRAMES:
				begin
					b_d.rdata[15:0] = d_q.frames;
				end
				default:
				begin
					b_d.rresp = dcr_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			b_q <= '0;
			b_q.hold <= dcr_pkg::CTRL_HOLD_RST;
		end
		else
		begin
			b_q <= b_d;
		end
	end

	assign s_axi_awready = ~b_q.aw_held;
	assign s_axi_wready = ~b_q.w_held;
	assign s_axi_bvalid = b_q.bvalid;
	assign s_axi_bresp = b_q.bresp;
	assign s_axi_arready = ~b_q.rvalid;
	assign s_axi_rvalid = b_q.rvalid;
	assign s_axi_rdata = b_q.rdata;
	assign s_axi_rresp = b_q.rresp;

	////////////////////////////////////////////////////////////////////////////
	// dac state: frame-end toggle crossing and code / power-mode register

	// word is stable for a whole frame after each toggle, so sampling it on the
	// synced toggle edge is safe; a host that restarts a frame and completes
	// 16 bits within ~3 clk periods would outrun this
	assign frame_evt = d_q.tgl_sync[1] ^ d_q.tgl_seen;

	always_comb
	begin
		d_d = d_q;
		d_d.tgl_sync = {d_q.tgl_sync[0], lk.tgl};
		d_d.tgl_seen = d_q.tgl_sync[1];
		d_d.fsel_sync = {d_q.fsel_sync[0], frame_sel_n};
		apply = 1'b0;
		new_word = lk.word;
		if (soft_go)
		begin
			apply = 1'b1;
			new_word = soft_word;
		end
		else if (frame_evt && !b_q.hold)
		begin
			apply = 1'b1;
		end
		if (apply)
		begin
			// top two bits are don't care
			d_d.mode = dcr_pkg::dcr_pmode_t'(new_word[dcr_pkg::MODE_MSB:dcr_pkg::MODE_LSB]);
			d_d.amp_on = 1'b0;
			d_d.gnd_1k = 1'b0;
			d_d.gnd_100k = 1'b0;
			// power-down keeps the old code; only a normal-mode word reloads it
			case (d_d.mode)
				dcr_pkg::DCR_PM_NORMAL:
				begin
					d_d.code = new_word[dcr_pkg::CODE_MSB:dcr_pkg::CODE_LSB];
					d_d.amp_on = 1'b1;
				end
				dcr_pkg::DCR_PM_1K:
				begin
					d_d.gnd_1k = 1'b1;
				end
				dcr_pkg::DCR_PM_100K:
				begin
					d_d.gnd_100k = 1'b1;
				end
				default:
				begin
					// high impedance: amplifier and both ground paths off
				end
			endcase
			d_d.frames = d_q.frames + dcr_pkg::FRAMES_ONE;
		end
	end

	// clear holds this in reset, so no frame end can land while it is low
	always_ff @(posedge clk or negedge dac_rst_n)
	begin
		if (!dac_rst_n)
		begin
			d_q.tgl_sync <= 2'h0;
			d_q.tgl_seen <= 1'b0;
			d_q.fsel_sync <= 2'h3;
			d_q.code <= dcr_pkg::CODE_ZERO;
			d_q.mode <= dcr_pkg::DCR_PM_NORMAL;
			d_q.amp_on <= 1'b1;
			d_q.gnd_1k <= 1'b0;
			d_q.gnd_100k <= 1'b0;
			d_q.frames <= dcr_pkg::FRAMES_RST;
		end
		else
		begin
			d_q <= d_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// string tap select: level = low ref + span * tap / 4096

	assign dac_tap = d_q.code;
	assign power_mode_hi = d_q.mode[1];
	assign power_mode_lo = d_q.mode[0];
	assign amp_enable = d_q.amp_on;
	assign gnd_1k_en = d_q.gnd_1k;
	assign gnd_100k_en = d_q.gnd_100k;

endmodule

// [test/dcr_chk.sv]
// Purpose: port checks of dcr_top
// Assumes: async pins are settled at clk edges
// Notes: bound into every dcr_top
`timescale 1ns/10ps
module dcr_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_zero_n,
	input wire logic frame_sel_n,
	input wire logic serial_chain_oe,
	input wire logic [dcr_pkg::CODE_W-1:0] dac_tap,
	input wire logic power_mode_hi,
	input wire logic power_mode_lo,
	input wire logic amp_enable,
	input wire logic gnd_1k_en,
	input wire logic gnd_100k_en,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_arvalid,
	input wire logic [dcr_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [1:0] pm;
	assign pm = {power_mode_hi, power_mode_lo};
	////////////////////////////////////////
	// soft writes excluded: their latency is not pinned down
	sequence s_clr_rel;
		!async_zero_n ##1 async_zero_n && !s_axi_awvalid;
	endsequence
	AST_CLR_ZERO: assert property (!async_zero_n |-> dac_tap == 12'h000 && pm == 2'h0)
		else $error("clear low with dac state set");
	AST_CLR_REL: assert property (s_clr_rel |-> (dac_tap == 12'h000) [*3])
		else $error("dac moved right after clear release");
	AST_NORM: assert property (pm == 2'h0 |-> amp_enable && !gnd_1k_en && !gnd_100k_en)
		else $error("normal mode enables wrong");
	AST_PD_1K: assert property (pm == 2'h1 |-> {amp_enable, gnd_1k_en, gnd_100k_en} == 3'h2)
		else $error("1k mode enables wrong");
	AST_PD_100K: assert property (pm == 2'h2 |-> {amp_enable, gnd_1k_en, gnd_100k_en} == 3'h1)
		else $error("100k mode enables wrong");
	AST_PD_HIZ: assert property (pm == 2'h3 |-> {amp_enable, gnd_1k_en, gnd_100k_en} == 3'h0)
		else $error("hi-z mode enables wrong");
	AST_TAP_KEEP: assert property ($changed(dac_tap) && async_zero_n |-> pm == 2'h0)
		else $error("code moved in power-down");
	// the bench never stalls rready, so the check is on the answer having a request behind it
	AST_R_ANS: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
		else $error("read answer without a request");
	AST_CHAIN_OE: assert property (serial_chain_oe == !frame_sel_n)
		else $error("chain output enable wrong");
endmodule
bind dcr_top dcr_chk u_dcr_chk
(
	.clk, .rst_n, .async_zero_n, .frame_sel_n, .serial_chain_oe, .dac_tap, .power_mode_hi, .power_mode_lo,
	.amp_enable, .gnd_1k_en, .gnd_100k_en, .s_axi_awvalid, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready
);

// [test/dcr_host.sv]
// Purpose: serial host model driving the link
// Assumes: 80 ns shift clock, only inside frames
// Notes: data line carries no pull, so idle shows the inverse
`timescale 1ns/10ps
module dcr_host
(
	output logic shift_clk,
	output logic frame_sel_n,
	output logic serial_in
);
	initial
	begin
		shift_clk = 1'b0;
		frame_sel_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic send(input logic [15:0] w);
		#7 frame_sel_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			#20 shift_clk = 1'b1;
			serial_in = w[i];
			#40 shift_clk = 1'b0;
			#20;
		end
		frame_sel_n = 1'b1;
		serial_in = ~serial_in;
		// gap leaves room for the clk-side crossing
		#600;
	endtask
endmodule

// [test/tb_dac_code_reset_powerdown_ctrl.sv]
// Purpose: self-checking bench of dcr_top
// Assumes: host model drives the link, bench drives axi4-lite
// Notes: outputs sampled after the host gap
`timescale 1ns/10ps
module tb_dac_code_reset_powerdown_ctrl;
	logic clk, rst_n, async_zero_n, shift_clk, frame_sel_n, serial_in, serial_chain_out, serial_chain_oe;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic power_mode_hi, power_mode_lo, amp_enable, gnd_1k_en, gnd_100k_en;
	logic [dcr_pkg::CODE_W-1:0] dac_tap;
	int err_total, tests_run;
	typedef struct packed {logic [15:0] w; logic [11:0] t;} dcr_row_t;
	dcr_row_t rows [6] = '{{16'hc123, 12'h123}, {16'h1abc, 12'h123}, {16'h2fff, 12'h123},
		{16'h3000, 12'h123}, {16'h0fff, 12'hfff}, {16'h0000, 12'h000}};
	localparam logic [1:0] OK = dcr_pkg::RESP_OKAY;
	dcr_top u_dcr_top
	(
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_clk, .frame_sel_n, .serial_in,
		.serial_chain_out, .serial_chain_oe, .async_zero_n, .dac_tap, .power_mode_hi, .power_mode_lo,
		.amp_enable, .gnd_1k_en, .gnd_100k_en
	);
	dcr_host u_dcr_host (.shift_clk, .frame_sel_n, .serial_in);
	////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic look(input string nm, input logic [1:0] m, input logic [11:0] t);
		chk(nm, {m, m == 2'h0, m == 2'h1, m == 2'h2, t},
			{power_mode_hi, power_mode_lo, amp_enable, gnd_1k_en, gnd_100k_en, dac_tap});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && n < 40);
		if (!s_axi_bvalid)
		begin
			err_total++;
			tally_and_finish();
		end
		chk("bresp", e, s_axi_bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 40);
		if (!s_axi_rvalid)
		begin
			err_total++;
			tally_and_finish();
		end
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
	endtask
	////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{err_total, tests_run} = 0;
		{rst_n, s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid} = '0;
		async_zero_n = 1'b1;
		// both answer readies stay high: the bench never stalls a response
		{s_axi_bready, s_axi_rready} = 2'h3;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		look("por", 2'h0, 12'h000);
		for (int i = 0; i < 6; i++)
		begin
			u_dcr_host.send(rows[i].w);
			@(posedge clk);
			look("row", rows[i].w[13:12], rows[i].t);
			chk("chain", {31'h0, rows[i].w[15]}, {31'h0, serial_chain_out});
		end
		rd(dcr_pkg::OFS_FRAMES, 32'h6, OK);
		rd(dcr_pkg::OFS_STATUS, 32'h4000, OK);
		rd(8'h10, 32'h0, dcr_pkg::RESP_SLVERR);
		wr(8'h20, 32'h1, 4'hf, dcr_pkg::RESP_SLVERR);
		wr(dcr_pkg::OFS_CTRL, 32'h1, 4'h1, OK);
		rd(dcr_pkg::OFS_CTRL, 32'h1, OK);
		// hold set: a finished frame must leave the dac alone
		u_dcr_host.send(16'h0555);
		@(posedge clk);
		look("hold", 2'h0, 12'h000);
		wr(dcr_pkg::OFS_CTRL, 32'h0, 4'h1, OK);
		wr(dcr_pkg::OFS_SOFT, 32'h0fff, 4'hf, OK);
		// lane 0 only: upper code bits come from the current word
		wr(dcr_pkg::OFS_SOFT, 32'h00ab, 4'h1, OK);
		repeat (4) @(posedge clk);
		look("soft", 2'h0, 12'hfab);
		rd(dcr_pkg::OFS_SOFT, 32'h0fab, OK);
		// no clk edge between the clear and this look
		async_zero_n <= 1'b0;
		#1 look("clr", 2'h0, 12'h000);
		u_dcr_host.send(16'h0777);
		@(posedge clk);
		look("clr_low", 2'h0, 12'h000);
		rd(dcr_pkg::OFS_FRAMES, 32'h0, OK);
		async_zero_n <= 1'b1;
		repeat (6) @(posedge clk);
		look("clr_rel", 2'h0, 12'h000);
		u_dcr_host.send(16'h0321);
		@(posedge clk);
		look("first", 2'h0, 12'h321);
		tally_and_finish();
	end
endmodule
